// file: inc/ser_cfg_pkg.sv
package ser_cfg_pkg;

  localparam logic [7:0] OFF_GENERAL_CONFIG_THREE = 8'h03;
  localparam logic [7:0] OFF_WIDTH_SELECT_CONTROL = 8'h05;

  localparam int AUTO_ACK_BIT = 4;
  localparam int FWD_ALL_BIT = 3;
  localparam int PASS_BIT = 2;
  localparam int PLL_OVR_BIT = 1;
  localparam int EDGE_BIT = 0;
  localparam logic [4:0] CFG3_RESET = 5'h05;

  localparam int OVR_BIT = 5;
  localparam int CURRENT_BIT = 4;
  localparam int ST12_BIT = 3;
  localparam int ST10_BIT = 2;
  localparam logic [1:0] SEL_TWELVE = 2'h2;
  localparam logic [1:0] SEL_TEN = 2'h1;
  localparam logic [1:0] WSEL_RESET = 2'h0;

  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [1:0] PH_ADDR = 2'h0;
  localparam logic [1:0] PH_PTR = 2'h1;
  localparam logic [1:0] PH_DATA = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RECV = 3'h1,
    ST_ACK = 3'h3,
    ST_SEND = 3'h2,
    ST_MACK = 3'h6,
    ST_WAIT = 3'h7,
    ST_IGNORE = 3'h5
  } bus_state_t;

endpackage

// file: inc/slice_if.sv
`timescale 1ns/1ps
`default_nettype none
interface slice_if;
  logic [6:0] addr;
  logic is_write;
  logic [6:0] own_id;
  logic [6:0] des_id;
  logic [6:0] des_alias;
  logic [6:0] tgt_id;
  logic [6:0] tgt_alias;
  logic fwd_all;
  logic pass_en;
  logic auto_en;
  logic rx_lock;
  logic hit_local;
  logic hit_fwd;
  logic [6:0] remap;
  logic auto_ack;
  logic ovr;
  logic [1:0] wsel;
  logic bc_twelve;
  logic bc_ten;
  logic bc_valid;
  logic tx_twelve;
  logic tx_ten;
  logic current;

  modport ctl (
    output addr, is_write, own_id, des_id, des_alias, tgt_id, tgt_alias,
    output fwd_all, pass_en, auto_en, rx_lock, ovr, wsel, bc_twelve, bc_ten, bc_valid,
    input hit_local, hit_fwd, remap, auto_ack, tx_twelve, tx_ten, current
  );
  modport dec (
    input addr, is_write, own_id, des_id, des_alias, tgt_id, tgt_alias,
    input fwd_all, pass_en, auto_en, rx_lock,
    output hit_local, hit_fwd, remap, auto_ack
  );
  modport mode (
    input ovr, wsel, bc_twelve, bc_ten, bc_valid,
    output tx_twelve, tx_ten, current
  );
endinterface
`default_nettype wire

// file: src/fwd_decider.sv
`timescale 1ns/1ps
`default_nettype none
module fwd_decider #(
  parameter int id_width = 7
) (
  slice_if.dec sif
);
  initial begin
    if (id_width != 7) begin
      $error("fwd_decider serves 7-bit target IDs only");
    end
  end

  logic own;
  logic des_ok;
  logic tgt_ok;
  logic alias_des;
  logic alias_tgt;
  logic direct_des;
  logic direct_tgt;
  logic all_hit;

  always_comb begin
    own = sif.addr == sif.own_id;
    des_ok = sif.des_id != 7'h00;
    tgt_ok = sif.tgt_id != 7'h00;
    alias_des = sif.pass_en && des_ok && sif.des_alias != 7'h00 && sif.addr == sif.des_alias;
    alias_tgt = sif.pass_en && tgt_ok && sif.tgt_alias != 7'h00 && sif.addr == sif.tgt_alias;
    direct_des = des_ok && sif.addr == sif.des_id;
    direct_tgt = tgt_ok && sif.addr == sif.tgt_id;
    all_hit = sif.fwd_all && des_ok;
    sif.hit_local = own;
    sif.hit_fwd = !own && (alias_des || alias_tgt || direct_des || direct_tgt || all_hit);
    sif.auto_ack = sif.auto_en && sif.rx_lock && sif.is_write && sif.hit_fwd &&
                   (alias_des || direct_des || sif.fwd_all);
    if (sif.fwd_all || sif.auto_ack || !(alias_tgt || direct_tgt)) begin
      sif.remap = sif.des_id;
    end else begin
      sif.remap = sif.tgt_id;
    end
  end
endmodule
`default_nettype wire

// file: src/width_mode_select.sv
`timescale 1ns/1ps
`default_nettype none
module width_mode_select (
  input wire logic clk,
  input wire logic resetn,
  slice_if.mode sif
);
  typedef struct packed {
    logic tx_twelve;
    logic tx_ten;
    logic current;
  } mode_state_t;

  mode_state_t q;
  mode_state_t d;

  always_comb begin
    d = q;
    d.current = sif.bc_valid;
    if (sif.ovr) begin
      d.tx_twelve = sif.wsel == ser_cfg_pkg::SEL_TWELVE;
      d.tx_ten = sif.wsel == ser_cfg_pkg::SEL_TEN;
    end else begin
      d.tx_twelve = sif.bc_twelve;
      d.tx_ten = sif.bc_ten;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sif.tx_twelve = q.tx_twelve;
  assign sif.tx_ten = q.tx_ten;
  assign sif.current = q.current;
endmodule
`default_nettype wire

// file: src/serializer_i2c_forward_mode_config.sv
`timescale 1ns/1ps
`default_nettype none
module serializer_i2c_forward_mode_config (
  input wire logic clk,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [6:0] own_id,
  input wire logic [6:0] des_id,
  input wire logic [6:0] des_alias,
  input wire logic [6:0] tgt_id,
  input wire logic [6:0] tgt_alias,
  input wire logic rx_lock,
  input wire logic mode_strap_osc,
  input wire logic pll_source_reg_osc,
  input wire logic bc_twelve,
  input wire logic bc_ten,
  input wire logic bc_valid,
  input wire logic remote_vld,
  input wire logic remote_ack,
  input wire logic [7:0] remote_rdata,
  output logic fwd_start,
  output logic [6:0] fwd_addr,
  output logic fwd_read,
  output logic fwd_auto_ack,
  output logic fwd_wr_vld,
  output logic [7:0] fwd_wr_data,
  output logic fwd_rd_req,
  output logic pll_clk_from_osc,
  output logic pixel_edge_rising,
  output logic twelve_bit_mode,
  output logic ten_bit_mode
);
  typedef struct packed {
    ser_cfg_pkg::bus_state_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [1:0] phase;
    logic rd;
    logic fwd;
    logic auto_wr;
    logic nack;
    logic [7:0] ptr;
    logic [4:0] cfg3;
    logic ovr;
    logic [1:0] wsel;
    logic sda_oe;
    logic scl_oe;
    logic scl_r;
    logic sda_r;
    logic pll_osc;
    logic fwd_start;
    logic fwd_rd_req;
    logic fwd_wr_vld;
    logic [6:0] fwd_addr;
    logic [7:0] fwd_data;
  } ctl_state_t;

  localparam ctl_state_t CTL_RESET = '{
    st: ser_cfg_pkg::ST_IDLE,
    cfg3: ser_cfg_pkg::CFG3_RESET,
    wsel: ser_cfg_pkg::WSEL_RESET,
    scl_r: 1'b1,
    sda_r: 1'b1,
    default: '0
  };

  ctl_state_t q;
  ctl_state_t d;
  slice_if sif ();

  fwd_decider #(
    .id_width(7)
  ) u_decider (
    .sif(sif)
  );

  width_mode_select u_mode (
    .clk(clk),
    .resetn(resetn),
    .sif(sif)
  );

  assign sif.addr = q.sh[7:1];
  assign sif.is_write = !q.sh[0];
  assign sif.own_id = own_id;
  assign sif.des_id = des_id;
  assign sif.des_alias = des_alias;
  assign sif.tgt_id = tgt_id;
  assign sif.tgt_alias = tgt_alias;
  assign sif.fwd_all = q.cfg3[ser_cfg_pkg::FWD_ALL_BIT];
  assign sif.pass_en = q.cfg3[ser_cfg_pkg::PASS_BIT];
  assign sif.auto_en = q.cfg3[ser_cfg_pkg::AUTO_ACK_BIT];
  assign sif.rx_lock = rx_lock;
  assign sif.ovr = q.ovr;
  assign sif.wsel = q.wsel;
  assign sif.bc_twelve = bc_twelve;
  assign sif.bc_ten = bc_ten;
  assign sif.bc_valid = bc_valid;

  function automatic logic [7:0] reg_read(input logic [7:0] ptr, input ctl_state_t s,
                                          input logic cur, input logic t12, input logic t10);
    logic [7:0] v;
    v = 8'h00;
    if (ptr == ser_cfg_pkg::OFF_GENERAL_CONFIG_THREE) begin
      v[4:0] = s.cfg3;
    end else if (ptr == ser_cfg_pkg::OFF_WIDTH_SELECT_CONTROL) begin
      v[ser_cfg_pkg::OVR_BIT] = s.ovr;
      v[ser_cfg_pkg::CURRENT_BIT] = cur;
      v[ser_cfg_pkg::ST12_BIT] = t12;
      v[ser_cfg_pkg::ST10_BIT] = t10;
      v[1:0] = s.wsel;
    end
    return v;
  endfunction

  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic load_rd;
  logic [7:0] rd_byte;

  always_comb begin
    scl_rise = scl_in && !q.scl_r;
    scl_fall = !scl_in && q.scl_r;
    start_seen = scl_in && q.scl_r && q.sda_r && !sda_in;
    stop_seen = scl_in && q.scl_r && !q.sda_r && sda_in;
    rd_byte = reg_read(q.ptr, q, sif.current, sif.tx_twelve, sif.tx_ten);
    load_rd = 1'b0;
    d = q;
    d.scl_r = scl_in;
    d.sda_r = sda_in;
    d.fwd_start = 1'b0;
    d.fwd_rd_req = 1'b0;
    d.fwd_wr_vld = 1'b0;
    d.pll_osc = q.cfg3[ser_cfg_pkg::PLL_OVR_BIT] ? pll_source_reg_osc : mode_strap_osc;
    if (start_seen) begin
      d.st = ser_cfg_pkg::ST_RECV;
      d.cnt = 4'h0;
      d.phase = ser_cfg_pkg::PH_ADDR;
      d.fwd = 1'b0;
      d.nack = 1'b0;
      d.sda_oe = 1'b0;
      d.scl_oe = 1'b0;
    end else if (stop_seen) begin
      d.st = ser_cfg_pkg::ST_IDLE;
      d.sda_oe = 1'b0;
      d.scl_oe = 1'b0;
    end else begin
      case (q.st)
        ser_cfg_pkg::ST_RECV: begin
          if (scl_rise) begin
            d.sh = {q.sh[6:0], sda_in};
            d.cnt = q.cnt + 4'h1;
          end else if (scl_fall && q.cnt == ser_cfg_pkg::BYTE_BITS) begin
            d.cnt = 4'h0;
            d.st = ser_cfg_pkg::ST_ACK;
            d.sda_oe = 1'b1;
            d.nack = 1'b0;
            if (q.phase == ser_cfg_pkg::PH_ADDR) begin
              d.rd = q.sh[0];
              d.auto_wr = sif.auto_ack;
              if (sif.hit_local) begin
                d.fwd = 1'b0;
              end else if (sif.hit_fwd) begin
                d.fwd = 1'b1;
                d.fwd_start = 1'b1;
                d.fwd_addr = sif.remap;
                if (!sif.auto_ack) begin
                  d.st = ser_cfg_pkg::ST_WAIT;
                  d.sda_oe = 1'b0;
                  d.scl_oe = 1'b1;
                end
              end else begin
                d.st = ser_cfg_pkg::ST_IGNORE;
                d.sda_oe = 1'b0;
              end
            end else if (q.fwd) begin
              d.fwd_wr_vld = 1'b1;
              d.fwd_data = q.sh;
              if (!q.auto_wr) begin
                d.st = ser_cfg_pkg::ST_WAIT;
                d.sda_oe = 1'b0;
                d.scl_oe = 1'b1;
              end
            end else if (q.phase == ser_cfg_pkg::PH_PTR) begin
              d.ptr = q.sh;
            end else begin
              d.ptr = q.ptr + 8'h01;
              if (q.ptr == ser_cfg_pkg::OFF_GENERAL_CONFIG_THREE) begin
                d.cfg3 = q.sh[4:0];
              end else if (q.ptr == ser_cfg_pkg::OFF_WIDTH_SELECT_CONTROL) begin
                d.ovr = q.sh[ser_cfg_pkg::OVR_BIT];
                d.wsel = q.sh[1:0];
              end
            end
          end
        end
        ser_cfg_pkg::ST_ACK: begin
          if (scl_fall) begin
            d.sda_oe = 1'b0;
            if (q.nack) begin
              d.st = ser_cfg_pkg::ST_IGNORE;
            end else if (q.rd) begin
              d.phase = ser_cfg_pkg::PH_DATA;
              load_rd = 1'b1;
            end else begin
              d.st = ser_cfg_pkg::ST_RECV;
              if (q.phase == ser_cfg_pkg::PH_ADDR && !q.fwd) begin
                d.phase = ser_cfg_pkg::PH_PTR;
              end else begin
                d.phase = ser_cfg_pkg::PH_DATA;
              end
            end
          end
        end
        ser_cfg_pkg::ST_SEND: begin
          if (scl_fall) begin
            d.sh = {q.sh[6:0], 1'b0};
            d.cnt = q.cnt + 4'h1;
            if (q.cnt == ser_cfg_pkg::BYTE_BITS - 4'h1) begin
              d.st = ser_cfg_pkg::ST_MACK;
              d.sda_oe = 1'b0;
            end else begin
              d.sda_oe = !q.sh[6];
            end
          end
        end
        ser_cfg_pkg::ST_MACK: begin
          if (scl_rise) begin
            d.nack = sda_in;
          end else if (scl_fall) begin
            if (q.nack) begin
              d.st = ser_cfg_pkg::ST_IGNORE;
            end else begin
              load_rd = 1'b1;
            end
          end
        end
        ser_cfg_pkg::ST_WAIT: begin
          if (remote_vld) begin
            d.scl_oe = 1'b0;
            if (q.rd && q.phase == ser_cfg_pkg::PH_DATA) begin
              d.sh = remote_rdata;
              d.cnt = 4'h0;
              d.st = ser_cfg_pkg::ST_SEND;
              d.sda_oe = !remote_rdata[7];
            end else begin
              d.st = ser_cfg_pkg::ST_ACK;
              d.sda_oe = remote_ack;
              d.nack = !remote_ack;
            end
          end
        end
        default: begin
        end
      endcase
    end
    // Next read byte: remote bytes stretch the clock until they arrive
    if (load_rd) begin
      d.cnt = 4'h0;
      if (q.fwd) begin
        d.st = ser_cfg_pkg::ST_WAIT;
        d.scl_oe = 1'b1;
        d.fwd_rd_req = 1'b1;
      end else begin
        d.st = ser_cfg_pkg::ST_SEND;
        d.sh = rd_byte;
        d.ptr = q.ptr + 8'h01;
        d.sda_oe = !rd_byte[7];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      q <= CTL_RESET;
    end else begin
      q <= d;
    end
  end

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = q.scl_oe;
  assign sda_oe = q.sda_oe;
  assign fwd_start = q.fwd_start;
  assign fwd_addr = q.fwd_addr;
  assign fwd_read = q.rd;
  assign fwd_auto_ack = q.auto_wr;
  assign fwd_wr_vld = q.fwd_wr_vld;
  assign fwd_wr_data = q.fwd_data;
  assign fwd_rd_req = q.fwd_rd_req;
  assign pll_clk_from_osc = q.pll_osc;
  assign pixel_edge_rising = q.cfg3[ser_cfg_pkg::EDGE_BIT];
  assign twelve_bit_mode = sif.tx_twelve;
  assign ten_bit_mode = sif.tx_ten;
endmodule
`default_nettype wire

// file: testbench/remote_partner.sv
`timescale 1ns/1ps
`default_nettype none
module remote_partner (
  input wire logic clk,
  input wire logic resetn,
  input wire logic slow,
  input wire logic req,
  output logic remote_vld,
  output logic remote_ack,
  output logic [7:0] remote_rdata
);
  logic [5:0] cnt_q;
  logic busy_q;
  // Between answers the data lines show the inverse pattern, not a stale byte
  assign remote_ack = remote_vld;
  assign remote_rdata = remote_vld ? 8'ha5 : 8'h5a;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      busy_q <= 1'b0;
      remote_vld <= 1'b0;
      cnt_q <= 6'h00;
    end else begin
      remote_vld <= busy_q && cnt_q == 6'h00;
      if (busy_q) begin
        cnt_q <= cnt_q - 6'h01;
        busy_q <= cnt_q != 6'h00;
      end else if (req) begin
        busy_q <= 1'b1;
        cnt_q <= slow ? 6'h28 : 6'h02;
      end
    end
  end
endmodule
`default_nettype wire

// file: testbench/serializer_i2c_forward_mode_config_checker.sv
`timescale 1ns/1ps
`default_nettype none
module serializer_i2c_forward_mode_config_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic [6:0] des_id,
  input wire logic [6:0] tgt_id,
  input wire logic rx_lock,
  input wire logic mode_strap_osc,
  input wire logic pll_source_reg_osc,
  input wire logic remote_vld,
  input wire logic remote_ack,
  input wire logic fwd_start,
  input wire logic [6:0] fwd_addr,
  input wire logic fwd_read,
  input wire logic fwd_auto_ack,
  input wire logic pll_clk_from_osc,
  input wire logic twelve_bit_mode,
  input wire logic ten_bit_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_osc_choice_src: assert property ((mode_strap_osc == pll_source_reg_osc) [*3]
    |-> pll_clk_from_osc == $past(mode_strap_osc)) else $error("pll source wrong");
  a_modes_exclusive: assert property (!(twelve_bit_mode && ten_bit_mode))
    else $error("both width modes");
  a_stretch_hold: assert property (scl_oe && !remote_vld |=> scl_oe)
    else $error("scl released early");
  a_stretch_release: assert property (remote_vld && scl_oe |-> ##[1:2] !scl_oe)
    else $error("scl not released");
  a_auto_no_wait: assert property (fwd_start && fwd_auto_ack |-> !scl_oe [*8])
    else $error("auto ack stretched");
  a_auto_needs_lock: assert property (fwd_start && fwd_auto_ack |-> $past(rx_lock))
    else $error("auto ack without lock");
  a_fwd_target: assert property (fwd_start |-> fwd_addr == des_id || fwd_addr == tgt_id)
    else $error("bad remap");
  a_remote_ack_pass: assert property (remote_vld && scl_oe && !fwd_read
    |=> sda_oe == $past(remote_ack)) else $error("remote ack lost");
  c_auto_fwd: cover property (fwd_start && fwd_auto_ack);
  c_stretch: cover property (remote_vld && scl_oe);
  c_twelve: cover property (twelve_bit_mode);
endmodule
bind serializer_i2c_forward_mode_config serializer_i2c_forward_mode_config_checker u_chk (
  .clk, .resetn, .scl_oe, .sda_oe, .des_id, .tgt_id, .rx_lock, .mode_strap_osc,
  .pll_source_reg_osc, .remote_vld, .remote_ack, .fwd_start, .fwd_addr, .fwd_read,
  .fwd_auto_ack, .pll_clk_from_osc, .twelve_bit_mode, .ten_bit_mode
);
`default_nettype wire

// file: testbench/serializer_i2c_forward_mode_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
module serializer_i2c_forward_mode_config_tb;
  localparam logic [6:0] own = 7'h58;
  localparam logic [6:0] des = 7'h2a;
  localparam logic [6:0] des_al = 7'h3c;
  localparam logic [6:0] tgt = 7'h50;
  localparam logic [6:0] tgt_al = 7'h44;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic scl_h = 1'b1;
  logic sda_h = 1'b1;
  logic strap = 1'b0;
  logic regosc = 1'b0;
  logic lock = 1'b1;
  logic b12 = 1'b0;
  logic b10 = 1'b1;
  logic bv = 1'b1;
  logic slow = 1'b1;
  logic scl_oe, sda_oe, rvld, rack, fstart, fread, fauto, fwvld, frdreq, posc, pedge, m12, m10;
  logic [7:0] rdata, fwdata;
  logic [6:0] faddr, last_addr;
  logic last_auto;
  logic last_read;
  logic [7:0] last_wdata;
  logic [6:0] des_v = des;
  wire logic scl_w = scl_h & ~scl_oe;
  wire logic sda_w = sda_h & ~sda_oe;
  int errors = 0;
  int samples_checked = 0;
  int n_fwd = 0;
  serializer_i2c_forward_mode_config DUT (
    .clk(clk), .resetn(resetn), .scl_in(scl_w), .sda_in(sda_w), .scl_out(), .scl_oe(scl_oe),
    .sda_out(), .sda_oe(sda_oe), .own_id(own), .des_id(des_v), .des_alias(des_al),
    .tgt_id(tgt), .tgt_alias(tgt_al), .rx_lock(lock), .mode_strap_osc(strap),
    .pll_source_reg_osc(regosc), .bc_twelve(b12), .bc_ten(b10), .bc_valid(bv),
    .remote_vld(rvld), .remote_ack(rack), .remote_rdata(rdata), .fwd_start(fstart),
    .fwd_addr(faddr), .fwd_read(fread), .fwd_auto_ack(fauto), .fwd_wr_vld(fwvld),
    .fwd_wr_data(fwdata), .fwd_rd_req(frdreq), .pll_clk_from_osc(posc),
    .pixel_edge_rising(pedge), .twelve_bit_mode(m12), .ten_bit_mode(m10)
  );
  remote_partner u_far (
    .clk(clk), .resetn(resetn), .slow(slow), .req((fstart || fwvld) && !fauto || frdreq),
    .remote_vld(rvld), .remote_ack(rack), .remote_rdata(rdata)
  );
  initial begin
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (fstart === 1'b1) begin
      n_fwd++;
      last_addr = faddr;
      last_auto = fauto;
      last_read = fread;
    end
    if (fwvld === 1'b1) begin
      last_wdata = fwdata;
    end
  end
  task automatic close_out;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic bit_io(input logic b, output logic r);
    int k;
    sda_h = b;
    tick(4);
    scl_h = 1'b1;
    k = 0;
    // Waits out clock stretching while the far side answers
    while (scl_w !== 1'b1 && k < 2000) begin
      tick(1);
      k++;
    end
    if (k == 2000) begin
      cmp("scl", 8'h01, 8'h00);
      close_out();
    end
    tick(2);
    r = sda_w;
    tick(2);
    scl_h = 1'b0;
  endtask
  task automatic byte_io(input logic [7:0] d, input logic nak, output logic [7:0] r,
                         output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], b);
      r[i] = b;
    end
    bit_io(nak, b);
    ack = !b;
  endtask
  task automatic start;
    sda_h = 1'b1;
    tick(4);
    scl_h = 1'b1;
    tick(4);
    sda_h = 1'b0;
    tick(4);
    scl_h = 1'b0;
  endtask
  task automatic stop;
    sda_h = 1'b0;
    tick(4);
    scl_h = 1'b1;
    tick(4);
    sda_h = 1'b1;
    tick(4);
  endtask
  task automatic xfer(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
                      output logic ack);
    logic [7:0] r;
    logic k;
    start();
    byte_io({a, 1'b0}, 1'b1, r, ack);
    if (ack) begin
      byte_io(p, 1'b1, r, k);
      byte_io(d, 1'b1, r, k);
    end
    stop();
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] v);
    logic k;
    start();
    if (a == own) begin
      byte_io({a, 1'b0}, 1'b1, v, k);
      byte_io(p, 1'b1, v, k);
      start();
    end
    byte_io({a, 1'b1}, 1'b1, v, k);
    byte_io(8'hff, 1'b1, v, k);
    stop();
  endtask
  task automatic t_reset;
    logic [7:0] v;
    rd(own, 8'h03, v);
    cmp("cfg3", 8'h05, v);
    rd(own, 8'h05, v);
    cmp("wsel", 8'h14, v);
    cmp("edge", 8'h01, {7'h00, pedge});
    strap = 1'b1;
    tick(3);
    cmp("osc", 8'h01, {7'h00, posc});
  endtask
  task automatic t_clock;
    logic a;
    xfer(own, 8'h03, 8'h06, a);
    tick(2);
    cmp("edge", 8'h00, {7'h00, pedge});
    cmp("osc", 8'h00, {7'h00, posc});
    regosc = 1'b1;
    strap = 1'b0;
    tick(3);
    cmp("osc", 8'h01, {7'h00, posc});
    xfer(own, 8'h03, 8'h05, a);
  endtask
  task automatic t_width;
    logic a;
    logic [7:0] v;
    b12 = 1'b1;
    b10 = 1'b0;
    tick(3);
    cmp("w12", 8'h01, {7'h00, m12});
    xfer(own, 8'h05, 8'h21, a);
    tick(2);
    cmp("w10", 8'h01, {7'h00, m10});
    rd(own, 8'h05, v);
    cmp("wsel", 8'h35, v);
    xfer(own, 8'h05, 8'h23, a);
    tick(2);
    cmp("both", 8'h00, {6'h00, m12, m10});
    xfer(own, 8'h05, 8'h01, a);
    bv = 1'b0;
    tick(2);
    cmp("wbc", 8'h02, {6'h00, m12, m10});
    rd(own, 8'h05, v);
    cmp("wsel", 8'h09, v);
  endtask
  task automatic t_fwd;
    logic a;
    logic [7:0] v;
    int n;
    xfer(des_al, 8'h10, 8'h5a, a);
    cmp("ack", 8'h01, {7'h00, a});
    cmp("addr", {1'b0, des}, {1'b0, last_addr});
    cmp("wdata", 8'h5a, last_wdata);
    slow = 1'b0;
    xfer(tgt_al, 8'h11, 8'h5b, a);
    cmp("addr", {1'b0, tgt}, {1'b0, last_addr});
    xfer(7'h11, 8'h00, 8'h00, a);
    cmp("ack", 8'h00, {7'h00, a});
    xfer(own, 8'h03, 8'h01, a);
    n = n_fwd;
    xfer(des_al, 8'h12, 8'h5c, a);
    cmp("ack", 8'h00, {7'h00, a});
    cmp("nfwd", 8'(n), 8'(n_fwd));
    xfer(own, 8'h03, 8'h09, a);
    xfer(7'h11, 8'h13, 8'h5d, a);
    cmp("ack", 8'h01, {7'h00, a});
    cmp("addr", {1'b0, des}, {1'b0, last_addr});
    rd(des_al, 8'h00, v);
    cmp("rdata", 8'ha5, v);
    cmp("fread", 8'h01, {7'h00, last_read});
  endtask
  task automatic t_auto;
    logic a;
    slow = 1'b1;
    xfer(own, 8'h03, 8'h15, a);
    xfer(des_al, 8'h20, 8'h66, a);
    cmp("ack", 8'h01, {7'h00, a});
    cmp("auto", 8'h01, {7'h00, last_auto});
    cmp("addr", {1'b0, des}, {1'b0, last_addr});
    lock = 1'b0;
    xfer(des_al, 8'h21, 8'h67, a);
    cmp("auto", 8'h00, {7'h00, last_auto});
    cmp("ack", 8'h01, {7'h00, a});
    des_v = 7'h00;
    xfer(des_al, 8'h22, 8'h68, a);
    cmp("ack", 8'h00, {7'h00, a});
  endtask
  initial begin
    tick(10);
    resetn = 1'b1;
    tick(2);
    t_reset();
    t_clock();
    t_width();
    t_fwd();
    t_auto();
    close_out();
  end
endmodule
`default_nettype wire
